// ### logic/frl_pkg.sv
// package for the ramp limit and trigger control block
// assumes a 16-bit register word carried on a 32-bit apb bus
package frl_pkg;
    // byte addresses: printed offsets are not all multiples of four,
    // so each printed offset is an index and the address is index * 4
    localparam logic [7:0] IDX_THRESH_HI = 8'h4E;
    localparam logic [7:0] IDX_THRESH_MID = 8'h4F;
    localparam logic [7:0] IDX_THRESH_LO = 8'h50;
    localparam logic [7:0] IDX_UPPER_TOP = 8'h51;
    localparam logic [7:0] IDX_UPPER_MID = 8'h52;
    localparam logic [7:0] IDX_UPPER_LO = 8'h53;
    localparam logic [7:0] IDX_LOWER_TOP = 8'h54;
    localparam logic [7:0] IDX_LOWER_MID = 8'h55;
    localparam logic [7:0] IDX_LOWER_LO = 8'h56;
    localparam logic [7:0] IDX_BURST = 8'h60;
    localparam logic [7:0] IDX_TRIG = 8'h61;
    // own registers: ramp control and status
    localparam logic [7:0] IDX_RAMP_CTRL = 8'h70;
    localparam logic [7:0] IDX_RAMP_STAT = 8'h71;
    // field positions
    localparam int THRESH_TOP_BIT = 11;
    localparam int FAST_RECAL_BIT = 9;
    localparam int CAP_LSB = 1;
    localparam int BURST_EN_BIT = 15;
    localparam int BURST_CNT_LSB = 2;
    localparam int RESYNC_BIT = 15;
    localparam int TRIGB_LSB = 7;
    localparam int TRIGA_LSB = 3;
    localparam int RUN_EN_BIT = 15;
    localparam int MANUAL_BIT = 5;
    localparam int ADV_SRC_LSB = 0;
    // reset values
    localparam logic [15:0] THRESH_HI_RST = 16'h0001;
    localparam logic [15:0] TRIG_RST = 16'h0800;
    localparam logic [15:0] ZERO_RST = 16'h0000;
    localparam logic [7:0] CAP_BAND_MAX = 8'hB7;
    // pin trigger codes
    localparam logic [3:0] TRG_OFF = 4'h0;
    localparam logic [3:0] TRG_CLK_RISE = 4'h1;
    localparam logic [3:0] TRG_DIR_RISE = 4'h2;
    localparam logic [3:0] TRG_ALWAYS = 4'h4;
    localparam logic [3:0] TRG_CLK_FALL = 4'h9;
    localparam logic [3:0] TRG_DIR_FALL = 4'hA;
    // event source codes
    localparam logic [1:0] SRC_OWN = 2'h0;
    localparam logic [1:0] SRC_TRIG_A = 2'h1;
    localparam logic [1:0] SRC_TRIG_B = 2'h2;
    // burst state
    typedef enum logic [1:0] {FRL_IDLE, FRL_RUN, FRL_DONE} frl_state_type;
endpackage

// ### logic/frl_trig_sel.sv
// one multipurpose trigger: picks a pin edge or constant by code
// assumes the edge pulses come from synchronised pins on pclk
`timescale 1ns/1ps
`default_nettype none
module frl_trig_sel (
    // selector
    input wire logic [3:0] sel,
    // edge pulses
    input wire logic clk_rise,
    input wire logic clk_fall,
    input wire logic dir_rise,
    input wire logic dir_fall,
    // result
    output logic fire
);
    import frl_pkg::*;
    // reserved codes never fire, so a bad code stays quiet
    assign fire = (sel == TRG_CLK_RISE) ? clk_rise :
                  (sel == TRG_DIR_RISE) ? dir_rise :
                  (sel == TRG_ALWAYS) ? 1'b1 :
                  (sel == TRG_CLK_FALL) ? clk_fall :
                  (sel == TRG_DIR_FALL) ? dir_fall : 1'b0;
endmodule // frl_trig_sel
`default_nettype wire

// ### logic/frl_ctrl.sv
// ramp limit, recalibration threshold, trigger and burst control
// assumes an apb master on pclk; ramp pins are asynchronous inputs
// Function
// - Ramp registers act only while the ramp run enable bit is set; the code leaves manual_mode, fast_recal_from_last and initial_cap_band ungated.
// - A 33-bit threshold asks for a calibration when the offset exceeds it.
// - Fast recal starts the search from the last found settings.
// - The 8-bit start band is used unless overridden; software keeps it <=183.
// - The ramp offset is clamped to a 33-bit upper bound.
// - The ramp offset is clamped to a lower bound held as 2^33 minus offset.
// - Burst mode runs exactly the burst count of ramps after enable rises.
// - The burst counter steps on ramp transition, trigger A or trigger B.
// - First segment resync clears its accumulator at each ramp start; the code clears it only in automatic mode.
// - Trigger A comes from a 4-bit selector of pin edges or always.
// - Trigger B uses its own selector with the same encoding.
// - Manual select bit 0 means automatic mode, 1 means manual mode.
// - First segment advances on its timeout, trigger A or trigger B.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module frl_ctrl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // ramp pins
    input wire logic ramp_clock_pin,
    input wire logic ramp_direction_pin,
    // ramp engine side
    input wire logic [32:0] ramp_offset,
    input wire logic ramp_transition,
    input wire logic first_segment_timeout,
    input wire logic ramp_start,
    // outputs to ramp engine and calibration
    output logic ramp_active,
    output logic manual_mode,
    output logic trigger_a,
    output logic trigger_b,
    output logic first_segment_advance,
    output logic first_segment_clear,
    output logic recal_request,
    output logic fast_recal_from_last,
    output logic [7:0] initial_cap_band,
    output logic at_upper_bound,
    output logic at_lower_bound,
    output logic burst_done
);
    import frl_pkg::*;

    // register storage
    logic [15:0] thr_hi_q, thr_mid_q, thr_lo_q;
    logic [15:0] up_top_q, up_mid_q, up_lo_q;
    logic [15:0] lo_top_q, lo_mid_q, lo_lo_q;
    logic [15:0] burst_q, trig_q, ctrl_q;
    logic run_q, run_prev_q;
    logic [12:0] burst_cnt_q;
    frl_state_type state_q;
    // pin synchronisers and edge history
    logic [1:0] clk_sync_q, dir_sync_q;
    logic clk_last_q, dir_last_q;

    // index decode; word aligned, unaligned access is an error
    wire logic [7:0] idx = paddr[9:2];
    wire logic aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction
    wire logic mapped = aligned && (hit(idx, IDX_THRESH_HI) ||
        hit(idx, IDX_THRESH_MID) || hit(idx, IDX_THRESH_LO) ||
        hit(idx, IDX_UPPER_TOP) || hit(idx, IDX_UPPER_MID) ||
        hit(idx, IDX_UPPER_LO) || hit(idx, IDX_LOWER_TOP) ||
        hit(idx, IDX_LOWER_MID) || hit(idx, IDX_LOWER_LO) ||
        hit(idx, IDX_BURST) || hit(idx, IDX_TRIG) ||
        hit(idx, IDX_RAMP_CTRL) || hit(idx, IDX_RAMP_STAT));
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite && mapped;
    wire logic rd_setup = psel && !penable && !pwrite && mapped;
    wire logic [15:0] wd = pwdata[15:0];

    // zero wait state slave
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // register writes; fixed bits held at their constant values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_hi_q <= THRESH_HI_RST;
            thr_mid_q <= ZERO_RST;
            thr_lo_q <= ZERO_RST;
            up_top_q <= ZERO_RST;
            up_mid_q <= ZERO_RST;
            up_lo_q <= ZERO_RST;
            lo_top_q <= ZERO_RST;
            lo_mid_q <= ZERO_RST;
            lo_lo_q <= ZERO_RST;
            burst_q <= ZERO_RST;
            trig_q <= TRIG_RST;
            ctrl_q <= ZERO_RST;
        end else if (wr) begin
            if (hit(idx, IDX_THRESH_HI)) thr_hi_q <= (wd & 16'h0BFE) | 16'h0001;
            if (hit(idx, IDX_THRESH_MID)) thr_mid_q <= wd;
            if (hit(idx, IDX_THRESH_LO)) thr_lo_q <= wd;
            if (hit(idx, IDX_UPPER_TOP)) up_top_q <= wd & 16'h0001;
            if (hit(idx, IDX_UPPER_MID)) up_mid_q <= wd;
            if (hit(idx, IDX_UPPER_LO)) up_lo_q <= wd;
            if (hit(idx, IDX_LOWER_TOP)) lo_top_q <= wd & 16'h0001;
            if (hit(idx, IDX_LOWER_MID)) lo_mid_q <= wd;
            if (hit(idx, IDX_LOWER_LO)) lo_lo_q <= wd;
            if (hit(idx, IDX_BURST)) burst_q <= wd & 16'hFFFC;
            if (hit(idx, IDX_TRIG)) trig_q <= (wd & 16'h87FB) | 16'h0800;
            if (hit(idx, IDX_RAMP_CTRL)) ctrl_q <= wd & 16'h8023;
        end
    end

    // field views
    wire logic [32:0] thresh = {thr_hi_q[THRESH_TOP_BIT], thr_mid_q, thr_lo_q};
    wire logic [32:0] upper = {up_top_q[0], up_mid_q, up_lo_q};
    wire logic [32:0] lower = {lo_top_q[0], lo_mid_q, lo_lo_q};
    wire logic burst_en = burst_q[BURST_EN_BIT];
    wire logic [12:0] burst_len = burst_q[14:BURST_CNT_LSB];
    wire logic [1:0] burst_src = trig_q[1:0];
    wire logic [3:0] sel_a = trig_q[TRIGA_LSB +: 4];
    wire logic [3:0] sel_b = trig_q[TRIGB_LSB +: 4];
    wire logic resync = trig_q[RESYNC_BIT];
    wire logic [1:0] adv_src = ctrl_q[ADV_SRC_LSB +: 2];
    wire logic run_en = ctrl_q[RUN_EN_BIT];

    // status word: run, burst state and count
    wire logic [15:0] stat = {run_q, state_q == FRL_DONE, 1'b0, burst_cnt_q};

    // read mux; registered data output
    wire logic [15:0] rmux =
        hit(idx, IDX_THRESH_HI) ? thr_hi_q :
        hit(idx, IDX_THRESH_MID) ? thr_mid_q :
        hit(idx, IDX_THRESH_LO) ? thr_lo_q :
        hit(idx, IDX_UPPER_TOP) ? up_top_q :
        hit(idx, IDX_UPPER_MID) ? up_mid_q :
        hit(idx, IDX_UPPER_LO) ? up_lo_q :
        hit(idx, IDX_LOWER_TOP) ? lo_top_q :
        hit(idx, IDX_LOWER_MID) ? lo_mid_q :
        hit(idx, IDX_LOWER_LO) ? lo_lo_q :
        hit(idx, IDX_BURST) ? burst_q :
        hit(idx, IDX_TRIG) ? trig_q :
        hit(idx, IDX_RAMP_CTRL) ? ctrl_q :
        hit(idx, IDX_RAMP_STAT) ? stat : ZERO_RST;
    // read word captured in the setup cycle, so the zero-wait access
    // phase still hands out a flop; a refused read returns zero
    logic [31:0] prdata_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= rd_setup ? {16'h0000, rmux} : 32'h0000_0000;
        end
    end
    assign prdata = prdata_q;

    // pin synchronisers; only the second stage feeds edge logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sync_q <= 2'h0;
            dir_sync_q <= 2'h0;
            clk_last_q <= 1'b0;
            dir_last_q <= 1'b0;
        end else begin
            clk_sync_q <= {clk_sync_q[0], ramp_clock_pin};
            dir_sync_q <= {dir_sync_q[0], ramp_direction_pin};
            clk_last_q <= clk_sync_q[1];
            dir_last_q <= dir_sync_q[1];
        end
    end
    wire logic clk_rise = clk_sync_q[1] && !clk_last_q;
    wire logic clk_fall = !clk_sync_q[1] && clk_last_q;
    wire logic dir_rise = dir_sync_q[1] && !dir_last_q;
    wire logic dir_fall = !dir_sync_q[1] && dir_last_q;

    // the two multipurpose triggers, gated by run_q (ramp active), not by run enable alone
    logic fire_a, fire_b;
    frl_trig_sel u_trig_a (
        .sel(sel_a),
        .clk_rise(clk_rise),
        .clk_fall(clk_fall),
        .dir_rise(dir_rise),
        .dir_fall(dir_fall),
        .fire(fire_a)
    );
    frl_trig_sel u_trig_b (
        .sel(sel_b),
        .clk_rise(clk_rise),
        .clk_fall(clk_fall),
        .dir_rise(dir_rise),
        .dir_fall(dir_fall),
        .fire(fire_b)
    );
    assign trigger_a = run_q && fire_a;
    assign trigger_b = run_q && fire_b;

    // source pick shared by burst count and segment advance
    function automatic logic pick(input logic [1:0] s, input logic own,
                                  input logic a, input logic b);
        pick = (s == SRC_OWN) ? own : (s == SRC_TRIG_A) ? a :
               (s == SRC_TRIG_B) ? b : 1'b0;
    endfunction
    assign first_segment_advance =
        pick(adv_src, run_q && first_segment_timeout, trigger_a, trigger_b);
    wire logic burst_evt =
        pick(burst_src, run_q && ramp_transition, trigger_a, trigger_b);

    // burst sequencer; enable rise arms it, count reaching length stops it
    wire logic run_rise = run_en && !run_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= FRL_IDLE;
            burst_cnt_q <= 13'h0000;
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run_en;
            case (state_q)
                FRL_IDLE: begin
                    if (run_rise) begin
                        burst_cnt_q <= 13'h0000;
                        state_q <= FRL_RUN;
                    end
                end
                FRL_RUN: begin
                    if (!run_en) begin
                        state_q <= FRL_IDLE;
                    end else if (burst_en && burst_evt) begin
                        burst_cnt_q <= burst_cnt_q + 13'h0001;
                        if (burst_cnt_q + 13'h0001 >= burst_len) begin
                            state_q <= FRL_DONE;
                        end
                    end
                end
                FRL_DONE: begin
                    if (!run_en) state_q <= FRL_IDLE;
                end
                default: state_q <= FRL_IDLE;
            endcase
        end
    end

    // ramp runs while enabled, unless a burst has finished or burst mode is set with a zero burst length
    always_comb run_q = run_en && (state_q == FRL_RUN) &&
        !(burst_en && burst_len == 13'h0000);
    assign ramp_active = run_q;
    assign burst_done = state_q == FRL_DONE;
    assign manual_mode = ctrl_q[MANUAL_BIT];
    // resync only acts in automatic mode, software is told the same
    assign first_segment_clear =
        run_q && resync && !ctrl_q[MANUAL_BIT] && ramp_start;

    // recal request when offset magnitude passes the threshold
    wire logic neg = ramp_offset[32];
    wire logic [32:0] mag = neg ? (33'h0 - ramp_offset) : ramp_offset;
    assign recal_request = run_q && (mag > thresh);
    assign fast_recal_from_last = thr_hi_q[FAST_RECAL_BIT];
    // values above the valid range are clamped, a cheap guard
    wire logic [7:0] cap_raw = thr_hi_q[CAP_LSB +: 8];
    assign initial_cap_band = (cap_raw > CAP_BAND_MAX) ?
        CAP_BAND_MAX : cap_raw;

    // bound flags: lower bound is two's complement of the down offset
    assign at_upper_bound = run_q && !neg && (ramp_offset >= upper);
    assign at_lower_bound = run_q && neg && (ramp_offset <= lower);

    // checks; outputs against the register fields that should drive them
    a_trig_gated: assert property (
        @(posedge pclk) disable iff (!presetn)
        !run_en |-> !trigger_a && !trigger_b && !recal_request)
        else $error("trigger while ramp disabled");
    a_bound_gated: assert property (
        @(posedge pclk) disable iff (!presetn)
        !run_en |-> !at_upper_bound && !at_lower_bound)
        else $error("bound flag while ramp disabled");
    a_recal_thresh: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_q && !neg && ramp_offset > thresh |-> recal_request)
        else $error("recal missed");
    a_recal_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        !neg && ramp_offset <= thresh |-> !recal_request)
        else $error("recal without cause");
    a_fast_recal: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit(idx, IDX_THRESH_HI)
        |=> fast_recal_from_last == $past(wd[FAST_RECAL_BIT]))
        else $error("fast recal bit wrong");
    a_cap_range: assert property (
        @(posedge pclk) disable iff (!presetn)
        initial_cap_band <= CAP_BAND_MAX)
        else $error("cap band out of range");
    a_upper_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_q && !neg && ramp_offset >= upper |-> at_upper_bound)
        else $error("upper bound missed");
    a_lower_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        at_lower_bound |-> ramp_offset[32] && ramp_offset <= lower)
        else $error("lower bound wrong");
    a_burst_stop: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == FRL_DONE |-> !ramp_active)
        else $error("ramp after burst");
    a_burst_arm: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == FRL_IDLE && run_rise
        |=> state_q == FRL_RUN && burst_cnt_q == 13'h0000)
        else $error("burst not armed on enable edge");
    a_burst_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == FRL_DONE && run_en |=> state_q == FRL_DONE)
        else $error("burst restarted without enable edge");
    a_burst_count: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_q == FRL_RUN && run_en && burst_en && burst_evt
        |=> burst_cnt_q == $past(burst_cnt_q) + 13'h0001)
        else $error("burst count stuck");
    a_resync_auto: assert property (
        @(posedge pclk) disable iff (!presetn)
        first_segment_clear |-> !manual_mode && ramp_start)
        else $error("resync in manual");
    a_resync_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        !resync |-> !first_segment_clear)
        else $error("resync clear while disabled");
    a_trig_always: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_q && sel_a == TRG_ALWAYS |-> trigger_a)
        else $error("always trigger a idle");
    a_trig_a_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        sel_a == TRG_OFF |-> !trigger_a)
        else $error("trigger a while off");
    a_trig_b_fall: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_q && sel_b == 4'h9 && $past(clk_sync_q[1]) && !clk_sync_q[1]
        |-> trigger_b)
        else $error("trigger b fall missed");
    a_trig_b_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        sel_b == TRG_OFF |-> !trigger_b)
        else $error("trigger b while off");
    a_adv_timeout: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_q && adv_src == SRC_OWN && first_segment_timeout
        |-> first_segment_advance)
        else $error("advance missed");
    a_manual_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit(idx, IDX_RAMP_CTRL)
        |=> manual_mode == $past(wd[MANUAL_BIT]))
        else $error("manual mode wrong");
endmodule // frl_ctrl
`default_nettype wire

// ### sim/frl_far_model.sv
// far-side model: ramp pins and ramp engine strobes and offset
// assumes the bench calls its tasks from the pclk domain
`timescale 1ns/1ps
`default_nettype none
module frl_far_model (
    // clock
    input wire logic pclk,
    // pins and ramp engine side
    output logic clk_pin,
    output logic dir_pin,
    output logic [32:0] offset,
    output logic [2:0] strobe
);
    // pins idle low, strobes quiet
    initial begin
        clk_pin = 1'b0;
        dir_pin = 1'b0;
        offset = 33'h0_0000_0000;
        strobe = 3'h0;
    end
    // one pin edge; level held until the next call, so the sync sees it
    task automatic flip(input logic which);
        @(posedge pclk);
        if (which) dir_pin <= ~dir_pin;
        else clk_pin <= ~clk_pin;
    endtask
    // strobe 0 transition, 1 timeout, 2 ramp start; one cycle wide
    task automatic pulse(input int k);
        @(posedge pclk);
        strobe[k] <= 1'b1;
        @(posedge pclk);
        strobe <= 3'h0;
    endtask
    // offset from the start frequency, two's complement
    task automatic set_off(input logic [32:0] v);
        @(posedge pclk);
        offset <= v;
    endtask
endmodule // frl_far_model
`default_nettype wire

// ### sim/test_frl_ctrl.sv
// self-checking bench for the ramp limit and trigger control block
// assumes zero-wait apb and a two-cycle pin-to-trigger delay
`timescale 1ns/1ps
`default_nettype none
module test_frl_ctrl;
    import frl_pkg::*;
    logic pclk, presetn, psel, penable;
    logic pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rclk, rdir, ract, man, ta, tb, adv, clr, rreq, fast, aup, alo;
    logic bdone;
    logic [32:0] roff;
    logic [2:0] stb;
    logic [7:0] cap;
    // two-state counters, so they start at zero
    int num_errors, num_checks, na, nb, nadv, nclr;
    always #20 pclk = ~pclk;
    frl_ctrl i_frl_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ramp_clock_pin(rclk), .ramp_direction_pin(rdir),
        .ramp_offset(roff), .ramp_transition(stb[0]),
        .first_segment_timeout(stb[1]), .ramp_start(stb[2]),
        .ramp_active(ract), .manual_mode(man), .trigger_a(ta),
        .trigger_b(tb), .first_segment_advance(adv),
        .first_segment_clear(clr), .recal_request(rreq),
        .fast_recal_from_last(fast), .initial_cap_band(cap),
        .at_upper_bound(aup), .at_lower_bound(alo), .burst_done(bdone));
    frl_far_model i_frl_far_model (.pclk(pclk), .clk_pin(rclk),
        .dir_pin(rdir), .offset(roff), .strobe(stb));
    // pulse counters sampled mid-cycle, away from the launching edge,
    // so one-cycle outputs are counted once and never raced
    always @(negedge pclk) begin
        na += int'(ta === 1'b1);
        nb += int'(tb === 1'b1);
        nadv += int'(adv === 1'b1);
        nclr += int'(clr === 1'b1);
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer: setup, access, wait for pready at an edge
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [15:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        if (n >= 16) chk(1'b0, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic w(input logic [7:0] idx, input logic [15:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic r(input logic [7:0] idx, input logic [15:0] exp);
        apb(1'b0, idx, 16'h0000);
        chk(rd, {16'h0000, exp});
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge pclk);
    endtask
    // one pin edge, then the count of pulses it caused on cnt
    task automatic edge_chk(input logic pin, ref int cnt, input int exp);
        int c0;
        c0 = cnt;
        i_frl_far_model.flip(pin);
        settle(6);
        chk(33'(cnt - c0), 33'(exp));
    endtask
    task automatic t_reset;
        r(IDX_THRESH_HI, 16'h0001);
        r(IDX_TRIG, 16'h0800);
        r(IDX_BURST, 16'h0000);
        r(IDX_UPPER_TOP, 16'h0000);
        r(8'h7F, 16'h0000);
        chk(err, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_cfg;
        w(IDX_THRESH_HI, 16'h02C9);
        w(IDX_THRESH_LO, 16'h0010);
        i_frl_far_model.set_off(33'h0_0000_0011);
        settle(2);
        chk(rreq, 1'b0);
        w(IDX_RAMP_CTRL, 16'h8000);
        settle(2);
        chk(rreq, 1'b1);
        i_frl_far_model.set_off(33'h0_0000_0010);
        settle(2);
        chk(rreq, 1'b0);
        chk(fast, 1'b1);
        chk(cap, 8'h64);
        w(IDX_THRESH_HI, 16'h0191);
        settle(2);
        chk(cap, CAP_BAND_MAX);
        w(IDX_RAMP_CTRL, 16'h8020);
        settle(2);
        chk(man, 1'b1);
        w(IDX_RAMP_CTRL, 16'h8000);
        $display("test config done");
    endtask
    task automatic t_bounds;
        w(IDX_UPPER_LO, 16'h0100);
        w(IDX_LOWER_TOP, 16'h0001);
        w(IDX_LOWER_MID, 16'hFFFF);
        w(IDX_LOWER_LO, 16'hFF00);
        i_frl_far_model.set_off(33'h0_0000_0100);
        settle(2);
        chk(aup, 1'b1);
        i_frl_far_model.set_off(33'h0_0000_00FF);
        settle(2);
        chk(aup, 1'b0);
        i_frl_far_model.set_off(33'h1_FFFF_FF00);
        settle(2);
        chk(alo, 1'b1);
        i_frl_far_model.set_off(33'h1_FFFF_FF01);
        settle(2);
        chk(alo, 1'b0);
        $display("test bounds done");
    endtask
    // every pin-edge code on both triggers, then always and off on trigger A
    task automatic t_trig;
        logic [3:0] codes [4];
        codes = '{TRG_CLK_RISE, TRG_DIR_RISE, TRG_CLK_FALL, TRG_DIR_FALL};
        for (int t = 0; t < 2; t++) begin
            for (int i = 0; i < 4; i++) begin
                w(IDX_TRIG, 16'h0800 | (16'(codes[i]) << (t ? 7 : 3)));
                if (t) edge_chk(i[0], nb, int'(i < 2));
                else edge_chk(i[0], na, int'(i < 2));
                if (t) edge_chk(i[0], nb, int'(i >= 2));
                else edge_chk(i[0], na, int'(i >= 2));
            end
        end
        w(IDX_TRIG, 16'h0800 | (16'(TRG_ALWAYS) << 3));
        settle(2);
        chk(ta, 1'b1);
        w(IDX_TRIG, 16'h0800);
        edge_chk(1'b0, na, 0);
        edge_chk(1'b0, na, 0);
        $display("test triggers done");
    endtask
    task automatic t_adv;
        int c0;
        c0 = nadv;
        i_frl_far_model.pulse(1);
        settle(2);
        chk(33'(nadv - c0), 33'h1);
        w(IDX_RAMP_CTRL, 16'h8001);
        w(IDX_TRIG, 16'h0908);
        c0 = nadv;
        i_frl_far_model.pulse(1);
        settle(2);
        chk(33'(nadv - c0), 33'h0);
        edge_chk(1'b0, nadv, 1);
        edge_chk(1'b0, nadv, 0);
        w(IDX_RAMP_CTRL, 16'h8002);
        edge_chk(1'b1, nadv, 1);
        edge_chk(1'b1, nadv, 0);
        w(IDX_TRIG, 16'h8800);
        c0 = nclr;
        i_frl_far_model.pulse(2);
        settle(2);
        chk(33'(nclr - c0), 33'h1);
        w(IDX_TRIG, 16'h0800);
        c0 = nclr;
        i_frl_far_model.pulse(2);
        settle(2);
        chk(33'(nclr - c0), 33'h0);
        $display("test advance done");
    endtask
    task automatic t_burst;
        w(IDX_RAMP_CTRL, 16'h0000);
        w(IDX_BURST, 16'h8008);
        w(IDX_RAMP_CTRL, 16'h8000);
        settle(2);
        chk({ract, bdone}, 2'b10);
        i_frl_far_model.pulse(0);
        settle(2);
        chk(bdone, 1'b0);
        i_frl_far_model.pulse(0);
        settle(2);
        chk({ract, bdone}, 2'b01);
        for (int s = 1; s < 3; s++) begin
            w(IDX_RAMP_CTRL, 16'h0000);
            w(IDX_TRIG, 16'h0908 | 16'(s));
            w(IDX_BURST, 16'h8004);
            w(IDX_RAMP_CTRL, 16'h8000);
            i_frl_far_model.pulse(0);
            i_frl_far_model.flip(s == 1);
            settle(6);
            chk(bdone, 1'b0);
            i_frl_far_model.flip(s == 2);
            settle(6);
            chk(bdone, 1'b1);
            i_frl_far_model.flip(1'b0);
            i_frl_far_model.flip(1'b1);
        end
        $display("test burst done");
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog: the tests take well under 100 us
    initial begin
        #400us;
        num_errors++;
        wrap_up();
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_cfg();
        t_bounds();
        t_trig();
        t_adv();
        t_burst();
        wrap_up();
    end
endmodule // test_frl_ctrl
`default_nettype wire
